// >>> pkg/flash_seq_pkg.sv
// Overview of operation
// (RQ1) Wrap command: opcode 77h, 24 dummy bits, one 8-bit wrap byte, select low.
// (RQ2) Wrap byte bit 7 and bits 3..0 are ignored.
// (RQ3) Disable bit 0: length 00/01/10/11 gives 8/16/32/64-byte section; 1 disables.
// (RQ4) Stored wrap setting holds for all later quad reads in any page.
// (RQ5) Disable bit powers up 1; only another wrap command turns wrapping off.
// (RQ6) Host should send a wrap command with disable set after system reset.
// (RQ7) Mode bits 5..4 equal 10 repeat the read next frame without opcode.
// (RQ8) Continuous mode only for BBh, EBh, E7h and E3h reads, via mode byte.
// (RQ9) Reserved mode bits accepted with any value, no effect.
// (RQ10) Continuous reset forces mode bit 4 to 1, leaving continuous mode.
// (RQ11) Reset is FFh over eight quad clocks, FFFFh over sixteen dual clocks.
// (RQ12) Host should send continuous reset first after any system reset.
// (RQ13) Page program: 02h, 24-bit address, data bytes on lane 0, select low.
// (RQ14) Program and erase rejected unless write enable latch is 1.
// (RQ15) Program address wraps inside the 256-byte page; extra bytes overwrite.
// (RQ16) Partial page program leaves other bytes of the page unchanged.
// (RQ17) Select must rise on a byte boundary or the command is discarded.
// (RQ18) Accepted program or erase starts self-timed cycle; busy reads 1 until done.
// (RQ19) Write enable latch cleared when program or erase cycle completes.
// (RQ20) Program or erase into a protected region is not executed.
// (RQ21) Quad page program 32h needs four-lane enable; data four bits per clock.
// (RQ22) Sector erase 20h with address sets the 4 KB sector to FFh.
// (RQ23) While busy, program and erase opcodes are ignored.
// (RQ24) Programming only clears bits; only erase sets them back to 1.
package flash_seq_pkg;
  localparam logic [7:0]  OP_WRAP     = 8'h77;
  localparam logic [7:0]  OP_PROG     = 8'h02;
  localparam logic [7:0]  OP_QPROG    = 8'h32;
  localparam logic [7:0]  OP_SERASE   = 8'h20;
  localparam logic [7:0]  OP_WREN     = 8'h06;
  localparam logic [7:0]  OP_DREAD    = 8'hBB;
  localparam logic [7:0]  OP_QREAD    = 8'hEB;
  localparam logic [7:0]  OP_WREAD    = 8'hE7;
  localparam logic [7:0]  OP_OREAD    = 8'hE3;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  // Wrap byte fields
  localparam int          WRAP_DIS_POS = 4;
  localparam int          WRAP_LEN_LSB = 5;
  localparam logic        WRAP_DIS_RST = 1'b1;
  localparam logic [7:0]  WRAP_MIN_BYTES = 8'h08;
  localparam logic [5:0]  WRAP_FRAME_CLKS = 6'h08;  // 6 dummy + 2 wrap byte clocks on four lanes
  // Mode byte fields
  localparam int          CONT_LSB   = 4;
  localparam logic [1:0]  CONT_ENTER = 2'h2;
  localparam logic [7:0]  MODE_RST   = 8'hFF;
  // Array geometry
  localparam int          ADDR_W       = 24;
  localparam int          PAGE_BYTES   = 256;
  localparam logic [12:0] PAGE_LAST    = 13'h00FF;
  localparam logic [12:0] SECTOR_LAST  = 13'h0FFF;
  localparam logic [19:0] ARRAY_BYTES  = 20'h8_0000;
  localparam logic [19:0] BLOCK_UNIT   = 20'h1_0000;
  localparam logic [19:0] SECTOR_UNIT  = 20'h0_1000;
  // Self-timed busy minimum, in clock cycles
  localparam int          TMR_W           = 24;
  localparam int          PROG_BUSY_CYC   = 1000;
  localparam int          ERASE_BUSY_CYC  = 20000;
endpackage : flash_seq_pkg

// >>> pkg/link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Sampled link events, all in the clock domain
interface link_if;
  logic       sclk_rise;
  logic       cs_fall;
  logic       cs_rise;
  logic       cs_low;
  logic [3:0] lanes;
  modport src (output sclk_rise, cs_fall, cs_rise, cs_low, lanes);
  modport dst (input sclk_rise, cs_fall, cs_rise, cs_low, lanes);
endinterface : link_if
`default_nettype wire

// >>> verilog/link_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module link_sampler (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] lanes_in,
  link_if.src             lk
);
  typedef struct packed {
    logic [2:0]      cs;
    logic [2:0]      ck;
    logic [1:0][3:0] ln;
  } smp_s;

  smp_s q;
  smp_s d;

  // Two stages for every pin; third stage only for edge finding
  always_comb begin
    d    = q;
    d.cs = {q.cs[1:0], cs_n};
    d.ck = {q.ck[1:0], sclk};
    d.ln = {q.ln[0], lanes_in};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '{cs: 3'h7, ck: 3'h0, ln: '0};
    end else begin
      q <= d;
    end
  end

  // Lanes from stage two line up with the clock edge seen at stage two
  assign lk.sclk_rise = q.ck[1] & ~q.ck[2];
  assign lk.cs_fall   = ~q.cs[1] & q.cs[2];
  assign lk.cs_rise   = q.cs[1] & ~q.cs[2];
  assign lk.cs_low    = ~q.cs[1];
  assign lk.lanes     = q.ln[1];
endmodule : link_sampler
`default_nettype wire

// >>> verilog/write_guard.sv
`timescale 1ns/1ps
`default_nettype none
module write_guard
  import flash_seq_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              protect_complement,
  input  wire logic              granularity_select,
  input  wire logic              top_bottom_select,
  input  wire logic [2:0]        block_guards,
  output logic                   locked
);
  logic [19:0] span;
  logic [19:0] a;
  logic        hit;
  logic [1:0]  sh;

  // Region grows by powers of two from one unit, capped at three doublings
  always_comb begin
    a    = {1'b0, addr[18:0]};
    sh   = (block_guards > 3'h4) ? 2'h3 : 2'(block_guards - 3'h1);
    span = '0;
    if (block_guards != 3'h0) begin
      span = (granularity_select ? SECTOR_UNIT : BLOCK_UNIT) << sh;
    end
    if (block_guards == 3'h7) begin
      hit = 1'b1;
    end else if (top_bottom_select) begin
      hit = a < span;
    end else begin
      hit = (span != 20'h0_0000) && (a >= ARRAY_BYTES - span);
    end
    locked = hit ^ protect_complement; // RQ20
  end
endmodule : write_guard
`default_nettype wire

// >>> verilog/serial_flash_wrap_program_erase.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_wrap_program_erase
  import flash_seq_pkg::*;
#(
  parameter int PROG_BUSY_CYCLES  = PROG_BUSY_CYC,
  parameter int ERASE_BUSY_CYCLES = ERASE_BUSY_CYC
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              data_lane_0,
  input  wire logic              data_lane_1,
  input  wire logic              data_lane_2,
  input  wire logic              data_lane_3,
  input  wire logic              four_lane_enable,
  input  wire logic              protect_complement,
  input  wire logic              granularity_select,
  input  wire logic              top_bottom_select,
  input  wire logic              block_guard_2,
  input  wire logic              block_guard_1,
  input  wire logic              block_guard_0,
  input  wire logic [7:0]        mem_rdata,
  output logic                   busy,
  output logic                   write_enable_latch,
  output logic                   wrap_disable_bit,
  output logic [1:0]             wrap_length_field,
  output logic [7:0]             wrap_bytes,
  output logic                   execute_in_place,
  output logic [7:0]             read_mode_byte,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [7:0]             mem_wdata
);
  typedef enum logic [5:0] {
    S_OP   = 6'h01,
    S_ADDR = 6'h02,
    S_DATA = 6'h04,
    S_WRAP = 6'h08,
    S_MODE = 6'h10,
    S_DONE = 6'h20
  } seq_e;

  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_RD   = 4'h2,
    E_WR   = 4'h4,
    E_WAIT = 4'h8
  } eng_e;

  typedef struct packed {
    seq_e                             st;
    eng_e                             es;
    logic                             skip;
    logic [7:0]                       op;
    logic [7:0]                       sh;
    logic [ADDR_W-1:0]                addr;
    logic [5:0]                       cnt;
    logic [7:0]                       pidx;
    logic                             got;
    logic                             cont;
    logic [7:0]                       cont_op;
    logic [7:0]                       mode;
    logic                             wrap_dis;
    logic [1:0]                       wrap_len;
    logic [7:0]                       wrap_bytes;
    logic                             wr_latch;
    logic                             busy;
    logic                             erase;
    logic [ADDR_W-1:0]                base;
    logic [12:0]                      widx;
    logic [TMR_W-1:0]                 timer;
    logic [PAGE_BYTES-1:0]            touched;
    logic [PAGE_BYTES-1:0][7:0]       pbuf;
    logic                             mem_we;
    logic [ADDR_W-1:0]                mem_addr;
    logic [7:0]                       mem_wdata;
  } st_s;

  st_s  q;
  st_s  d;
  logic locked;
  link_if lk ();

  // Lane count code: 0 single, 1 dual, 2 quad
  function automatic logic [1:0] addr_w(input logic [7:0] op);
    unique case (op)
      OP_DREAD:                     addr_w = 2'h1;
      OP_QREAD, OP_WREAD, OP_OREAD: addr_w = 2'h2;
      default:                      addr_w = 2'h0;
    endcase
  endfunction : addr_w

  function automatic logic [5:0] clks8(input logic [1:0] w);
    clks8 = (w == 2'h0) ? 6'h08 : (w == 2'h1) ? 6'h04 : 6'h02;
  endfunction : clks8

  function automatic logic [ADDR_W-1:0] shift_in(input logic [ADDR_W-1:0] v,
                                                 input logic [3:0] l, input logic [1:0] w);
    unique case (w)
      2'h0:    shift_in = {v[ADDR_W-2:0], l[0]};
      2'h1:    shift_in = {v[ADDR_W-3:0], l[1:0]};
      default: shift_in = {v[ADDR_W-5:0], l};
    endcase
  endfunction : shift_in

  function automatic logic is_write(input logic [7:0] op);
    is_write = (op == OP_PROG) || (op == OP_QPROG) || (op == OP_SERASE);
  endfunction : is_write

  link_sampler u_link (
    .clock    (clock),
    .nrst     (nrst),
    .cs_n     (cs_n),
    .sclk     (sclk),
    .lanes_in ({data_lane_3, data_lane_2, data_lane_1, data_lane_0}),
    .lk       (lk.src)
  );

  write_guard u_guard (
    .addr               (q.addr),
    .protect_complement (protect_complement),
    .granularity_select (granularity_select),
    .top_bottom_select  (top_bottom_select),
    .block_guards       ({block_guard_2, block_guard_1, block_guard_0}),
    .locked             (locked)
  );

  // Frame decoder and self-timed engine in one next-state process
  always_comb begin
    logic [1:0]        w;
    logic [ADDR_W-1:0] nv;
    logic [7:0]        nb;
    logic              ok;
    logic [ADDR_W-1:0] nt;
    w         = (q.op == OP_QPROG && q.st == S_DATA) ? 2'h2 : addr_w(q.op);
    nv        = '0;
    nb        = '0;
    ok        = 1'b0;
    nt        = '0;
    d         = q;
    d.mem_we  = 1'b0;
    if (lk.cs_fall) begin
      // Continuous mode skips the opcode and reuses the last read
      d.st   = q.cont ? S_ADDR : S_OP; // RQ7
      d.op   = q.cont ? q.cont_op : q.op;
      d.cnt  = '0;
      d.skip = 1'b0;
      d.got  = 1'b0;
    end else if (lk.cs_rise) begin
      // Only whole bytes count; a stray clock discards the command
      if (!q.skip && ((q.st == S_DATA && q.cnt == 6'h00 && q.got) ||
                      (q.st == S_DONE && q.op == OP_SERASE))) begin // RQ17
        ok = q.wr_latch && !q.busy && !locked; // RQ14 RQ20 RQ23
        if (q.op == OP_QPROG && !four_lane_enable) begin
          ok = 1'b0; // RQ21
        end
      end
      if (ok) begin
        d.busy  = 1'b1; // RQ18
        d.es    = E_RD;
        d.widx  = '0;
        d.erase = (q.op == OP_SERASE); // RQ22
        d.base  = (q.op == OP_SERASE) ? {q.addr[ADDR_W-1:12], 12'h000} : {q.addr[ADDR_W-1:8], 8'h00};
        d.timer = (q.op == OP_SERASE) ? TMR_W'(ERASE_BUSY_CYCLES) : TMR_W'(PROG_BUSY_CYCLES); // RQ18
      end
      if (!q.skip && q.st == S_DONE && q.op == OP_WREN && !q.busy) begin
        d.wr_latch = 1'b1;
      end
      d.skip = 1'b1;
    end else if (lk.sclk_rise && lk.cs_low && !q.skip) begin
      nv = shift_in(q.addr, lk.lanes, w);
      // Full-width shift first; a call result cannot be sliced directly
      nt = shift_in({16'h0000, q.sh}, lk.lanes, w);
      nb = nt[7:0];
      d.cnt = q.cnt + 6'h01;
      unique case (q.st)
        S_OP: begin
          nt   = shift_in({16'h0000, q.sh}, lk.lanes, 2'h0);
          nb   = nt[7:0];
          d.sh = nb;
          if (q.cnt == 6'h07) begin
            d.op  = nb;
            d.cnt = '0;
            if (q.busy && is_write(nb)) begin
              d.skip = 1'b1; // RQ23
            end else if (nb == OP_WRAP) begin
              d.st = S_WRAP; // RQ1
            end else if (nb == OP_WREN) begin
              d.st = S_DONE;
            end else if (is_write(nb) || addr_w(nb) != 2'h0) begin
              d.st = S_ADDR; // RQ8 RQ13
            end else begin
              d.skip = 1'b1;
            end
          end
        end
        S_ADDR: begin
          d.addr = nv;
          if (q.cnt == 6'(3 * clks8(w) - 6'h01)) begin
            d.cnt = '0;
            if (q.op == OP_SERASE) begin
              d.st = S_DONE;
            end else if (is_write(q.op)) begin
              d.st      = S_DATA;
              d.pidx    = nv[7:0];
              d.touched = '0;
            end else begin
              d.st = S_MODE;
            end
          end
        end
        S_DATA: begin
          d.sh = nb;
          if (q.cnt == clks8(w) - 6'h01) begin
            // Page pointer is 8 bits, so overflow lands back on the page start
            d.pbuf[q.pidx]    = nb; // RQ15 RQ21
            d.touched[q.pidx] = 1'b1; // RQ16
            d.pidx            = q.pidx + 8'h01; // RQ15
            d.got             = 1'b1;
            d.cnt             = '0;
          end
        end
        S_WRAP: begin
          // Dummy bits fall out of the top of the shifter
          nt   = shift_in({16'h0000, q.sh}, lk.lanes, 2'h2);
          nb   = nt[7:0];
          d.sh = nb;
          if (q.cnt == WRAP_FRAME_CLKS - 6'h01) begin
            d.wrap_dis   = nb[WRAP_DIS_POS]; // RQ2 RQ5
            d.wrap_len   = nb[WRAP_LEN_LSB +: 2]; // RQ2 RQ3
            d.wrap_bytes = nb[WRAP_DIS_POS] ? 8'h00 : (WRAP_MIN_BYTES << nb[WRAP_LEN_LSB +: 2]); // RQ3 RQ4
            d.skip       = 1'b1;
          end
        end
        S_MODE: begin
          d.sh = nb;
          if (q.cnt == clks8(w) - 6'h01) begin
            // Lane 0 carries bit 4, so an all-ones reset frame always exits
            d.mode    = nb; // RQ9 RQ10 RQ11
            d.cont    = (nb[CONT_LSB +: 2] == CONT_ENTER); // RQ7
            d.cont_op = q.op;
            d.skip    = 1'b1;
          end
        end
        S_DONE: begin
          d.skip = 1'b1; // RQ17
        end
      endcase
    end

    // Self-timed engine: read each touched byte, merge, write back; erase writes FFh to every byte of the sector
    if (q.timer != '0) begin
      d.timer = q.timer - TMR_W'(1);
    end
    unique case (q.es)
      E_IDLE: begin
      end
      E_RD: begin
        if (q.erase || q.touched[q.widx[7:0]]) begin
          d.mem_addr = q.erase ? {q.base[ADDR_W-1:12], q.widx[11:0]} : {q.base[ADDR_W-1:8], q.widx[7:0]};
          d.es       = E_WR;
        end else if (q.widx == PAGE_LAST) begin
          d.es = E_WAIT; // RQ16
        end else begin
          d.widx = q.widx + 13'h0001;
        end
      end
      E_WR: begin
        d.mem_we    = 1'b1;
        // AND with the stored byte: program only pulls bits low
        d.mem_wdata = q.erase ? ERASED_BYTE : (q.pbuf[q.widx[7:0]] & mem_rdata); // RQ22 RQ24
        d.widx      = q.widx + 13'h0001;
        d.es        = (q.widx == (q.erase ? SECTOR_LAST : PAGE_LAST)) ? E_WAIT : E_RD;
      end
      E_WAIT: begin
        if (q.timer == '0) begin
          d.busy = 1'b0; // RQ18
          d.wr_latch = 1'b0; // RQ19
          d.es   = E_IDLE;
        end
      end
    endcase
  end

  // Device has no reset pin; nrst stands for power-on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q            <= '0;
      q.st         <= S_OP;
      q.es         <= E_IDLE;
      q.skip       <= 1'b1;
      q.mode       <= MODE_RST;
      q.wrap_dis   <= WRAP_DIS_RST; // RQ5
      q.touched    <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign busy               = q.busy;
  assign write_enable_latch = q.wr_latch;
  assign wrap_disable_bit   = q.wrap_dis;
  assign wrap_length_field  = q.wrap_len;
  assign wrap_bytes         = q.wrap_bytes;
  assign execute_in_place   = q.cont;
  assign read_mode_byte     = q.mode;
  assign mem_we             = q.mem_we;
  assign mem_addr           = q.mem_addr;
  assign mem_wdata          = q.mem_wdata;
endmodule : serial_flash_wrap_program_erase
`default_nettype wire

// >>> bench/spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  input  wire logic       clock,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      lanes
);
  // Deselected and parked at time zero; clock stays low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    lanes = 4'h5;
  end
  // Select low, then a settle gap before the first clock
  task automatic open();
    @(negedge clock);
    cs_n = 1'b0;
    repeat (8) @(negedge clock);
  endtask : open
  // n clocks of w bits, MSB first; unused lanes flip so stale data never looks valid
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] mk;
    mk = 4'((1 << w) - 1);
    for (int i = n - 1; i >= 0; i--) begin
      lanes = (~lanes & ~mk) | (4'(v >> (i * w)) & mk);
      repeat (8) @(negedge clock);
      sclk = 1'b1;
      repeat (8) @(negedge clock);
      sclk = 1'b0;
    end
  endtask : send
  // Select rises only after the caller's last whole clock, then stays high
  task automatic close();
    repeat (8) @(negedge clock);
    cs_n = 1'b1;
    lanes = ~lanes;
    repeat (8) @(negedge clock);
  endtask : close
endmodule : spi_host
`default_nettype wire

// >>> bench/serial_flash_wrap_program_erase_props.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_wrap_program_erase_props
  import flash_seq_pkg::*;
#(
  parameter int PROG_BUSY_CYCLES = PROG_BUSY_CYC
) (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       cs_n,
  input wire logic [7:0] mem_rdata,
  input wire logic       busy,
  input wire logic       write_enable_latch,
  input wire logic       wrap_disable_bit,
  input wire logic [1:0] wrap_length_field,
  input wire logic [7:0] wrap_bytes,
  input wire logic       execute_in_place,
  input wire logic [7:0] read_mode_byte,
  input wire logic       mem_we,
  input wire logic [7:0] mem_wdata
);
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic [15:0] busy_len_q;
  // Length of the current busy stretch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_len_q <= 16'h0000;
    end else begin
      busy_len_q <= busy ? busy_len_q + 16'h0001 : 16'h0000;
    end
  end
  // Self-timed cycle, latch, array write, wrap size and read mode relations
  a_busy_needs_wel: assert property ($rose(busy) |-> $past(write_enable_latch))
    else $error("busy without write enable");
  a_busy_after_cs: assert property ($rose(busy) |-> cs_n && $past(cs_n, 2))
    else $error("busy started inside a frame");
  a_busy_min_len: assert property ($fell(busy) |-> busy_len_q >= 16'(PROG_BUSY_CYCLES - 1))
    else $error("busy too short");
  a_wel_clear_end: assert property ($fell(busy) |-> !write_enable_latch)
    else $error("latch kept after cycle");
  a_write_in_busy: assert property (mem_we |-> busy)
    else $error("array write outside busy");
  a_bits_only_clear: assert property (mem_we |-> mem_wdata == ERASED_BYTE || (mem_wdata & ~mem_rdata) == 8'h00)
    else $error("program set a bit");
  a_wrap_size_map: assert property ($stable({wrap_disable_bit, wrap_length_field})
      |-> wrap_bytes == (wrap_disable_bit ? 8'h00 : WRAP_MIN_BYTES << wrap_length_field))
    else $error("wrap size wrong");
  a_cont_entry_code: assert property ($rose(execute_in_place) |-> read_mode_byte[5:4] == CONT_ENTER)
    else $error("continuous mode without entry code");
endmodule : serial_flash_wrap_program_erase_props
bind serial_flash_wrap_program_erase serial_flash_wrap_program_erase_props #(
  .PROG_BUSY_CYCLES(PROG_BUSY_CYCLES)
) i_serial_flash_wrap_program_erase_props (
  .clock(clock), .nrst(nrst), .cs_n(cs_n), .mem_rdata(mem_rdata), .busy(busy),
  .write_enable_latch(write_enable_latch), .wrap_disable_bit(wrap_disable_bit),
  .wrap_length_field(wrap_length_field), .wrap_bytes(wrap_bytes), .execute_in_place(execute_in_place),
  .read_mode_byte(read_mode_byte), .mem_we(mem_we), .mem_wdata(mem_wdata));
`default_nettype wire

// >>> bench/serial_flash_wrap_program_erase_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_wrap_program_erase_tb;
  import flash_seq_pkg::*;
  logic              clock = 1'b0;
  logic              nrst = 1'b0;
  logic              cs_n, sclk, busy, wr_latch, wdis, cont_rd, we;
  logic [3:0]        lanes;
  logic              quad_en = 1'b0;
  logic [2:0]        guard = 3'h0;
  logic [1:0]        wlen;
  logic [7:0]        wbytes, rmode, wdata, m;
  logic [ADDR_W-1:0] maddr;
  logic [7:0]        mem [0:(1 << 19) - 1];
  logic [7:0]        rops [4] = '{OP_DREAD, OP_QREAD, OP_WREAD, OP_OREAD};
  logic [31:0]       exp_q [$];
  logic [31:0]       rng = 32'h0000_003C;
  logic [31:0]       e;
  int                n_errors = 0;
  int                checked = 0;
  // System clock
  always #5 clock = ~clock;
  spi_host i_spi_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .lanes(lanes));
  serial_flash_wrap_program_erase #(.PROG_BUSY_CYCLES(20), .ERASE_BUSY_CYCLES(50)) i_serial_flash_wrap_program_erase (
    .clock(clock), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .data_lane_0(lanes[0]), .data_lane_1(lanes[1]),
    .data_lane_2(lanes[2]), .data_lane_3(lanes[3]), .four_lane_enable(quad_en), .protect_complement(1'b0),
    .granularity_select(1'b0), .top_bottom_select(1'b0), .block_guard_2(guard[2]), .block_guard_1(guard[1]),
    .block_guard_0(guard[0]), .mem_rdata(mem[maddr[18:0]]), .busy(busy), .write_enable_latch(wr_latch),
    .wrap_disable_bit(wdis), .wrap_length_field(wlen), .wrap_bytes(wbytes), .execute_in_place(cont_rd),
    .read_mode_byte(rmode), .mem_we(we), .mem_addr(maddr), .mem_wdata(wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  // Array model; any write not noted beforehand is caught as a mismatch
  always @(posedge clock) begin
    if (we === 1'b1) begin
      if (exp_q.size() > 0) e = exp_q.pop_front();
      else e = 32'hFFFF_FFFF;
      chk({maddr, wdata}, e);
      mem[maddr[18:0]] <= wdata;
    end
  end
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd
  task automatic op8(input logic [7:0] op);
    i_spi_host.open();
    i_spi_host.send({24'h00_0000, op}, 8, 1);
  endtask : op8
  task automatic wren();
    op8(OP_WREN);
    i_spi_host.close();
  endtask : wren
  // Program n bytes; ok says whether writes are due, bz the busy level just after
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n, input logic ok, input logic bz);
    logic [7:0]  d;
    logic [23:0] x;
    logic [31:0] hi_q [$];
    op8(op);
    i_spi_host.send({8'h00, a}, 24, 1);
    for (int k = 0; k < n; k++) begin
      d = rnd();
      x = {a[23:8], a[7:0] + k[7:0]};
      // Engine walks the page from offset 0, so wrapped bytes land first
      if (ok && x[7:0] < a[7:0]) exp_q.push_back({x, d & mem[x[18:0]]});
      else if (ok) hi_q.push_back({x, d & mem[x[18:0]]});
      i_spi_host.send({24'h00_0000, d}, op == OP_QPROG ? 2 : 8, op == OP_QPROG ? 4 : 1);
    end
    while (hi_q.size() > 0) exp_q.push_back(hi_q.pop_front());
    i_spi_host.close();
    chk(busy, bz);
  endtask : prog
  // Erase with nb address bits, so 23 leaves select rising mid-byte
  task automatic erase(input logic [23:0] a, input int nb, input logic ok);
    op8(OP_SERASE);
    i_spi_host.send({8'h00, a} >> (24 - nb), nb, 1);
    for (int k = 0; k < 4096 && ok; k++) exp_q.push_back({a[23:12], k[11:0], ERASED_BYTE});
    i_spi_host.close();
    chk(busy, ok);
  endtask : erase
  task automatic idle();
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge clock);
    chk(busy, 1'b0);
    chk(wr_latch, 1'b0);
    chk(exp_q.size(), 0);
  endtask : idle
  task automatic wrap(input logic [7:0] w);
    op8(OP_WRAP);
    i_spi_host.send({rnd(), rnd(), rnd(), w}, 8, 4);
    i_spi_host.close();
  endtask : wrap
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    for (int i = 0; i < (1 << 19); i++) mem[i] = i < 1024 ? rnd() : 8'hFF;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    chk({busy, wr_latch, wdis, cont_rd, wlen, wbytes, rmode}, {4'h2, 2'h0, 8'h00, 8'hFF});
    i_spi_host.open();
    i_spi_host.send(32'hFFFF_FFFF, 16, 1);
    i_spi_host.close();
    wrap(8'h10);
    $display("test power-up done");
    for (int l = 0; l < 4; l++) begin
      wrap((rnd() & 8'h8F) | {1'b0, l[1:0], 5'h00});
      chk({wdis, wlen, wbytes}, {1'b0, l[1:0], 8'h08 << l});
    end
    wrap(rnd() | 8'h10);
    chk({wdis, wbytes}, 9'h100);
    $display("test wrap done");
    prog(OP_PROG, 24'h00_0010, 1, 1'b0, 1'b0);
    wren();
    chk(wr_latch, 1'b1);
    prog(OP_PROG, 24'h00_00FE, 3, 1'b1, 1'b1);
    idle();
    wren();
    prog(OP_QPROG, 24'h00_0200, 1, 1'b0, 1'b0);
    quad_en = 1'b1;
    prog(OP_QPROG, 24'h00_0240, 4, 1'b1, 1'b1);
    idle();
    $display("test program done");
    wren();
    erase(24'h00_1234, 23, 1'b0);
    erase(24'h00_1234, 24, 1'b1);
    prog(OP_PROG, 24'h00_0020, 1, 1'b0, 1'b1);
    idle();
    wren();
    guard = 3'h7;
    erase(24'h00_5000, 24, 1'b0);
    guard = 3'h0;
    $display("test erase done");
    op8(OP_QREAD);
    i_spi_host.send({24'h00_0100, rnd() & 8'hCF}, 8, 4);
    i_spi_host.close();
    chk(cont_rd, 1'b0);
    for (int j = 0; j < 4; j++) begin
      m = (rnd() & 8'hCF) | 8'h20;
      op8(rops[j]);
      i_spi_host.send({24'h00_0100, m}, j == 0 ? 16 : 8, j == 0 ? 2 : 4);
      i_spi_host.close();
      chk({cont_rd, rmode}, {1'b1, m});
      i_spi_host.open();
      i_spi_host.send(32'hFFFF_FFFF, j == 0 ? 16 : 8, j == 0 ? 2 : 4);
      i_spi_host.close();
      chk({cont_rd, rmode}, {1'b0, 8'hFF});
    end
    $display("test read mode done");
    tally_and_finish();
  end
  // Watchdog at roughly four times the expected run
  initial begin
    repeat (80000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
endmodule : serial_flash_wrap_program_erase_tb
`default_nettype wire
